// ==== rtl/eocm_regs.vh ====
// Register map, field positions and timing counts for the oscillator and multiplier control
`ifndef EOCM_REGS_VH
`define EOCM_REGS_VH
`define EOCM_ADDR_MULT_CTRL     8'hab
`define EOCM_ADDR_OSC_CTRL      8'hb1
`define EOCM_RESET_VAL          8'h00
`define EOCM_OSC_STABLE_BIT     7
`define EOCM_OSC_MODE_HI        6
`define EOCM_OSC_MODE_LO        4
`define EOCM_OSC_RSVD_BIT       3
`define EOCM_OSC_RANGE_HI       2
`define EOCM_OSC_RANGE_LO       0
`define EOCM_MUL_EN_BIT         7
`define EOCM_MUL_INIT_BIT       6
`define EOCM_MUL_LOCK_BIT       5
`define EOCM_MUL_SCALE_HI       4
`define EOCM_MUL_SCALE_LO       2
`define EOCM_MUL_SEL_HI         1
`define EOCM_MUL_SEL_LO         0
`define EOCM_MODE_CMOS          3'h2
`define EOCM_MODE_CMOS_DIV2     3'h3
`define EOCM_MODE_RC            3'h4
`define EOCM_MODE_CAP           3'h5
`define EOCM_MODE_XTAL          3'h6
`define EOCM_MODE_XTAL_DIV2     3'h7
`define EOCM_SEL_INT_DIV2       2'h0
`define EOCM_SEL_EXT            2'h1
`define EOCM_SEL_EXT_DIV2       2'h2
`define EOCM_SEL_INT            2'h3
// Crystal settle time in microseconds and the cycle count at 200 MHz
`define EOCM_XTAL_SETTLE_US     1000
`define EOCM_CLK_MHZ            200
`define EOCM_XTAL_SETTLE_CYC    (`EOCM_XTAL_SETTLE_US * `EOCM_CLK_MHZ)
// Multiplier lock time in nanoseconds and its cycle count
`define EOCM_LOCK_NS            5000
`define EOCM_CLK_NS             5
`define EOCM_LOCK_CYC           ((`EOCM_LOCK_NS + `EOCM_CLK_NS - 1) / `EOCM_CLK_NS)
// Fast pulse half period in core cycles
`define EOCM_FAST_HALF          1
`endif

// ==== rtl/eocm_scaler.v ====
// Output scaler: scales the x4 pulse train by 1, 2/3, 1/2, 2/5, 1/3 or 2/7
`include "eocm_regs.vh"
module eocm_scaler (
	// Clock and reset
	input  wire       core_clk,
	input  wire       srst,
	// Control
	input  wire       run,
	input  wire [2:0] scale,
	// Fast edge stream, one pulse per x4 output edge
	input  wire       edge_in,
	output reg        clk_out
);
	reg  [2:0] cnt_q;
	wire       unity = (scale < 3'h3);
	// Period of n edges: high for n/2 of them, rounded down
	wire [2:0] half  = scale >> 1;
	wire       wrap  = (cnt_q >= scale - 3'h1);

	// Odd divisors give unequal phases
	always @(posedge core_clk) begin
		if (srst || !run) begin
			cnt_q   <= 3'h0;
			clk_out <= 1'b0;
		end else if (edge_in) begin
			if (unity) begin
				clk_out <= ~clk_out;
			end else begin
				cnt_q   <= wrap ? 3'h0 : cnt_q + 3'h1;
				clk_out <= (cnt_q < half);
			end
		end
	end
endmodule

// ==== rtl/eocm_top.v ====
// External oscillator control and clock multiplier, register port and clock generation
// What this block does
// - Stable flag reads 1 when crystal runs
// - Mode field decodes off, CMOS, RC, cap, crystal
// - Reserved bit 3 reads zero, write zero
// - Multiplier output is four times input, scaled
// - Input select picks internal/external, halved or not
// - Init bit zero on enable; one starts init
// - Lock flag reads 1 once locked
// - Slow input gives four pulses then waits
// - Scaling field decodes factor 1 to 2/7
// - Odd factors give unequal duty cycle
`include "eocm_regs.vh"
module eocm_top #(
	parameter XTAL_SETTLE_CYC = `EOCM_XTAL_SETTLE_CYC
) (
	// Clock and reset
	input  wire       core_clk,
	input  wire       srst,
	// Register port
	input  wire [7:0] reg_addr,
	input  wire       reg_wr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	// Oscillator inputs from pins and analog cells
	input  wire       ext_osc_in,
	input  wire       int_osc_in,
	input  wire       crystal_amp_ok,
	// Oscillator controls
	output reg        ext_osc_enable,
	output reg  [2:0] ext_osc_mode,
	output reg  [2:0] ext_osc_range,
	output reg        ext_clk_out,
	// Multiplier output
	output reg        mult_clk_out,
	output reg        mult_lock_out
);
	////////////////////////////////////////////////////////////////////////
	reg  [2:0] ext_osc_mode_sel_q;
	reg  [2:0] ext_osc_freq_range_q;
	reg        mult_enable_bit_q;
	reg        mult_init_bit_q;
	reg        mult_lock_flag_q;
	reg  [2:0] mult_out_scale_q;
	reg  [1:0] mult_input_sel_q;
	reg        crystal_stable_flag_q;
	reg [31:0] settle_cnt_q;
	reg [15:0] lock_cnt_q;

	// Two-flop synchronisers for pin level inputs
	reg [2:0] s1_q;
	reg [2:0] s2_q;
	always @(posedge core_clk) begin
		if (srst) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
		end else begin
			s1_q <= {crystal_amp_ok, int_osc_in, ext_osc_in};
			s2_q <= s1_q;
		end
	end
	wire ext_s = s2_q[0];
	wire int_s = s2_q[1];
	wire amp_s = s2_q[2];

	////////////////////////////////////////////////////////////////////////
	// Register writes
	wire wr_osc = reg_wr && (reg_addr == `EOCM_ADDR_OSC_CTRL);
	wire wr_mul = reg_wr && (reg_addr == `EOCM_ADDR_MULT_CTRL);
	wire osc_on = ext_osc_mode_sel_q[2] | ext_osc_mode_sel_q[1];
	wire xtal_mode = (ext_osc_mode_sel_q[2:1] == 2'h3);
	wire lock_kill = !mult_enable_bit_q || (wr_mul && !reg_wdata[`EOCM_MUL_EN_BIT]);

	always @(posedge core_clk) begin
		if (srst) begin
			ext_osc_mode_sel_q   <= 3'h0;
			ext_osc_freq_range_q <= 3'h0;
			mult_enable_bit_q    <= 1'b0;
			mult_init_bit_q      <= 1'b0;
			mult_out_scale_q     <= 3'h0;
			mult_input_sel_q     <= 2'h0;
		end else begin
			if (wr_osc) begin
				ext_osc_mode_sel_q   <= reg_wdata[`EOCM_OSC_MODE_HI:`EOCM_OSC_MODE_LO];
				ext_osc_freq_range_q <= reg_wdata[`EOCM_OSC_RANGE_HI:`EOCM_OSC_RANGE_LO];
			end
			if (wr_mul) begin
				mult_enable_bit_q <= reg_wdata[`EOCM_MUL_EN_BIT];
				// Init only takes when already enabled
				mult_init_bit_q   <= reg_wdata[`EOCM_MUL_INIT_BIT] & mult_enable_bit_q;
				mult_out_scale_q  <= reg_wdata[`EOCM_MUL_SCALE_HI:`EOCM_MUL_SCALE_LO];
				mult_input_sel_q  <= reg_wdata[`EOCM_MUL_SEL_HI:`EOCM_MUL_SEL_LO];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Crystal stable flag: amplitude good for the settle time
	always @(posedge core_clk) begin
		if (srst || !xtal_mode || wr_osc) begin
			settle_cnt_q          <= 32'h0000_0000;
			crystal_stable_flag_q <= 1'b0;
		end else if (!amp_s) begin
			settle_cnt_q          <= 32'h0000_0000;
			crystal_stable_flag_q <= 1'b0;
		end else if (settle_cnt_q >= XTAL_SETTLE_CYC - 1) begin
			crystal_stable_flag_q <= 1'b1;
		end else begin
			settle_cnt_q <= settle_cnt_q + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// External oscillator clock path with optional divide by two
	reg ext_prev_q;
	reg ext_half_q;
	wire ext_rise = ext_s & ~ext_prev_q;
	wire ext_div2 = ext_osc_mode_sel_q[0] && (ext_osc_mode_sel_q != `EOCM_MODE_CAP);
	wire ext_clk  = ext_div2 ? ext_half_q : ext_s;
	always @(posedge core_clk) begin
		if (srst) begin
			ext_prev_q <= 1'b0;
			ext_half_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_s;
			if (ext_rise)
				ext_half_q <= ~ext_half_q;
		end
	end

	// Multiplier input select
	reg int_prev_q;
	reg int_half_q;
	reg mi_prev_q;
	reg ec_half_q;
	reg ec_prev_q;
	always @(posedge core_clk) begin
		if (srst) begin
			int_prev_q <= 1'b0;
			int_half_q <= 1'b0;
			ec_prev_q  <= 1'b0;
			ec_half_q  <= 1'b0;
		end else begin
			int_prev_q <= int_s;
			ec_prev_q  <= ext_clk;
			if (int_s & ~int_prev_q)
				int_half_q <= ~int_half_q;
			if (ext_clk & ~ec_prev_q)
				ec_half_q <= ~ec_half_q;
		end
	end
	reg mult_in;
	always @* begin
		case (mult_input_sel_q)
			`EOCM_SEL_INT_DIV2: mult_in = int_half_q;
			`EOCM_SEL_EXT:      mult_in = ext_clk;
			`EOCM_SEL_EXT_DIV2: mult_in = ec_half_q;
			`EOCM_SEL_INT:      mult_in = int_s;
			default:            mult_in = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Lock sequence
	always @(posedge core_clk) begin
		if (srst || lock_kill) begin
			lock_cnt_q       <= 16'h0000;
			mult_lock_flag_q <= 1'b0;
		end else if (wr_mul && reg_wdata[`EOCM_MUL_INIT_BIT]) begin
			lock_cnt_q       <= 16'h0000;
			mult_lock_flag_q <= 1'b0;
		end else if (mult_init_bit_q && !mult_lock_flag_q) begin
			if (lock_cnt_q >= `EOCM_LOCK_CYC - 1)
				mult_lock_flag_q <= 1'b1;
			else
				lock_cnt_q <= lock_cnt_q + 16'h0001;
		end
	end

	// Eight fast edges per rising input edge, then wait
	reg       mi_q;
	reg [2:0] burst_q;
	reg       fast_tgl_q;
	wire      in_rise = mult_in & ~mi_prev_q;
	wire      run     = mult_lock_flag_q;
	always @(posedge core_clk) begin
		if (srst || !run) begin
			mi_prev_q  <= 1'b0;
			burst_q    <= 3'h0;
			fast_tgl_q <= 1'b0;
			mi_q       <= 1'b0;
		end else begin
			mi_prev_q <= mult_in;
			mi_q      <= 1'b0;
			if (in_rise)
				burst_q <= 3'h4;
			else if (burst_q != 3'h0) begin
				fast_tgl_q <= ~fast_tgl_q;
				mi_q       <= 1'b1;
				if (fast_tgl_q)
					burst_q <= burst_q - 3'h1;
			end
		end
	end

	wire scaled;
	eocm_scaler u_scaler (
		.core_clk (core_clk),
		.srst     (srst),
		.run      (run),
		.scale    (mult_out_scale_q),
		.edge_in  (mi_q),
		.clk_out  (scaled)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs and read data
	always @(posedge core_clk) begin
		if (srst) begin
			reg_rdata      <= 8'h00;
			ext_osc_enable <= 1'b0;
			ext_osc_mode   <= 3'h0;
			ext_osc_range  <= 3'h0;
			ext_clk_out    <= 1'b0;
			mult_clk_out   <= 1'b0;
			mult_lock_out  <= 1'b0;
		end else begin
			ext_osc_enable <= osc_on;
			ext_osc_mode   <= ext_osc_mode_sel_q;
			ext_osc_range  <= ext_osc_freq_range_q;
			ext_clk_out    <= osc_on & ext_clk;
			mult_clk_out   <= scaled;
			mult_lock_out  <= mult_lock_flag_q;
			if (reg_addr == `EOCM_ADDR_OSC_CTRL)
				reg_rdata <= {crystal_stable_flag_q, ext_osc_mode_sel_q, 1'b0,
					ext_osc_freq_range_q};
			else if (reg_addr == `EOCM_ADDR_MULT_CTRL)
				reg_rdata <= {mult_enable_bit_q, mult_init_bit_q, mult_lock_flag_q,
					mult_out_scale_q, mult_input_sel_q};
			else
				reg_rdata <= 8'h00;
		end
	end
endmodule

// ==== tb/eocm_chk.sv ====
// Checker on the ports of the oscillator and multiplier control
module eocm_chk #(
	parameter XTAL_SETTLE_CYC = 50
) (
	// Clock and reset
	input wire       core_clk,
	input wire       srst,
	// Register port
	input wire [7:0] reg_addr,
	input wire       reg_wr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	// Oscillator side
	input wire       ext_osc_in,
	input wire       int_osc_in,
	input wire       crystal_amp_ok,
	input wire       ext_osc_enable,
	input wire [2:0] ext_osc_mode,
	input wire [2:0] ext_osc_range,
	input wire       ext_clk_out,
	// Multiplier side
	input wire       mult_clk_out,
	input wire       mult_lock_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////
	sequence s_osc_wr;
		reg_wr && reg_addr == 8'hb1;
	endsequence
	sequence s_osc_land;
		ext_osc_mode == $past(reg_wdata[6:4], 2) && ext_osc_range == $past(reg_wdata[2:0], 2);
	endsequence
	sequence s_lock_off;
		(!mult_lock_out) [*8];
	endsequence
	a_osc_fields_follow: assert property (s_osc_wr |-> ##2 s_osc_land)
		else $error("osc fields did not follow write");
	a_osc_enable_decode: assert property (ext_osc_enable == (ext_osc_mode[2:1] != 2'b00))
		else $error("osc enable disagrees with mode");
	a_ext_clk_off: assert property ((!ext_osc_enable) [*3] |-> !ext_clk_out)
		else $error("ext clock runs while off");
	a_rsvd_reads_zero: assert property ($past(reg_addr) == 8'hb1 |-> !reg_rdata[3])
		else $error("reserved bit read as one");
	a_stable_xtal_only: assert property ($past(reg_addr) == 8'hb1 && reg_rdata[7] |-> ext_osc_mode[2:1] == 2'b11)
		else $error("stable flag outside crystal mode");
	a_lock_flag_out: assert property ($past(reg_addr) == 8'hab |-> reg_rdata[5] == mult_lock_out)
		else $error("lock flag and lock output differ");
	a_lock_drop_dis: assert property (reg_wr && reg_addr == 8'hab && !reg_wdata[7] |-> ##[2:3] !mult_lock_out)
		else $error("lock kept after disable");
	a_lock_not_early: assert property (reg_wr && reg_addr == 8'hab && reg_wdata[6] |-> ##3 s_lock_off)
		else $error("lock too soon after init");
	a_mclk_quiet: assert property ((!mult_lock_out) [*3] |-> !mult_clk_out)
		else $error("multiplier clock before lock");
	a_unmapped_zero: assert property ($past(reg_addr) != 8'hab && $past(reg_addr) != 8'hb1 |-> reg_rdata == 8'h00)
		else $error("unmapped address read nonzero");
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the oscillator and clock multiplier control
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam SETTLE = 50;
	logic       core_clk = 0, srst = 1, reg_wr = 0;
	logic       ext_osc_in = 0, int_osc_in = 0, crystal_amp_ok = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, d, v;
	logic       b;
	wire  [7:0] reg_rdata;
	wire  [2:0] ext_osc_mode, ext_osc_range;
	wire        ext_osc_enable, ext_clk_out, mult_clk_out, mult_lock_out;
	int         miscompares = 0, checks_done = 0, cyc = 0, i, n, e;
	eocm_top #(.XTAL_SETTLE_CYC(SETTLE)) u_dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_osc_in(ext_osc_in),
		.int_osc_in(int_osc_in), .crystal_amp_ok(crystal_amp_ok), .ext_osc_enable(ext_osc_enable),
		.ext_osc_mode(ext_osc_mode), .ext_osc_range(ext_osc_range), .ext_clk_out(ext_clk_out),
		.mult_clk_out(mult_clk_out), .mult_lock_out(mult_lock_out));
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////
	// Oscillator inputs and run limit
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		ext_osc_in <= cyc[4];
		int_osc_in <= cyc[3];
		if (cyc == 30000) begin
			miscompares++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= x;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] x);
		@(posedge core_clk);
		reg_addr <= a;
		repeat (2) @(posedge core_clk);
		#1 x = reg_rdata;
	endtask
	// Read image with stable flag low and reserved bit cleared
	function automatic logic [7:0] exp_osc(input logic [7:0] x);
		return {1'b0, x[6:4], 1'b0, x[2:0]};
	endfunction
	// Output rises in cyc cycles: input x4, scaled by 2/m; input periods follow the pin drive
	function automatic int exp_rises(input logic [1:0] sel, input logic [2:0] sc, input int cyc);
		int per, m;
		per = (sel == 2'h3) ? 16 : (sel == 2'h2) ? 64 : 32;
		m = (sc < 3'h3) ? 2 : int'(sc);
		return (cyc / per) * 8 / m;
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(69));
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		rd(8'hab, v); `CHK(v, 8'h00)
		rd(8'hb1, v); `CHK(v, 8'h00)
		wr(8'hac, 8'hff); rd(8'hac, v); `CHK(v, 8'h00)
		$display("test reset and unmapped done");
		// Random range codes serve the RC and cap bands
		for (i = 0; i < 8; i++) begin
			d = {1'b1, i[2:0], 1'b0, 3'($urandom)};
			wr(8'hb1, d);
			rd(8'hb1, v); `CHK(v, exp_osc(d))
			`CHK(ext_osc_enable, (i >= 2))
			`CHK({ext_osc_mode, ext_osc_range}, {d[6:4], d[2:0]})
		end
		$display("test osc modes done");
		crystal_amp_ok <= 1'b1;
		d = {4'h6, 1'b0, 3'($urandom)};
		wr(8'hb1, d);
		rd(8'hb1, v); `CHK(v[7], 1'b0)
		repeat (SETTLE + 10) @(posedge core_clk);
		rd(8'hb1, v); `CHK(v, d | 8'h80)
		wr(8'hb1, 8'h20);
		rd(8'hb1, v); `CHK(v, 8'h20)
		$display("test crystal done");
		wr(8'hab, 8'h40); rd(8'hab, v); `CHK(v, 8'h00)
		// Ext source stays in clock mode and running slow sim rates
		for (i = 0; i < 8; i++) begin
			d = {3'b100, i[2:0], i[1:0]};
			wr(8'hab, 8'h00);
			wr(8'hab, d & 8'h1f);
			wr(8'hab, d);
			rd(8'hab, v); `CHK(v, d)
			repeat (1001) @(posedge core_clk);
			wr(8'hab, d | 8'h40);
			repeat (990) @(posedge core_clk);
			#1 `CHK(mult_lock_out, 1'b0)
			repeat (20) @(posedge core_clk);
			rd(8'hab, v); `CHK(v[5], 1'b1)
			n = 0;
			b = mult_clk_out;
			repeat (640) begin
				@(posedge core_clk);
				#1 n += (mult_clk_out & ~b);
				b = mult_clk_out;
			end
			e = exp_rises(d[1:0], d[4:2], 640);
			`CHK(n == e || n == e + 1, 1'b1)
		end
		wr(8'hab, 8'h00);
		repeat (3) @(posedge core_clk);
		#1 `CHK(mult_lock_out, 1'b0)
		$display("test multiplier done");
		final_report();
	end
endmodule
bind eocm_top eocm_chk #(.XTAL_SETTLE_CYC(XTAL_SETTLE_CYC)) u_chk (.core_clk(core_clk), .srst(srst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.ext_osc_in(ext_osc_in), .int_osc_in(int_osc_in), .crystal_amp_ok(crystal_amp_ok),
	.ext_osc_enable(ext_osc_enable), .ext_osc_mode(ext_osc_mode), .ext_osc_range(ext_osc_range),
	.ext_clk_out(ext_clk_out), .mult_clk_out(mult_clk_out), .mult_lock_out(mult_lock_out));
